// ---- hdl/pbd_pkg.sv ----
// constants for the peripheral block base decoder
// assumes a 24-bit internal address and 16-bit register words
`default_nettype none
package pbd_pkg;
    localparam int          ADDR_W          = 24;
    localparam int          DATA_W          = 16;
    localparam int          SPACE_W         = 3;
    localparam int          BLOCK_BITS      = 12;
    localparam int          TOP_BITS        = 4;
    // fixed register locations (byte addresses, word aligned)
    localparam logic [23:0] BASE_REG_ADDR   = 24'h0000F2;
    localparam logic [23:0] SCR_REG_ADDR    = 24'h0000F4;
    localparam logic [15:0] BASE_RESET      = 16'hBFFF;
    localparam logic [15:0] SCR_RESET       = 16'h0000;
    // base register fields
    localparam int          BASE_FIELD_MSB  = 11;
    localparam int          CFC_BIT         = 12;
    localparam int          SPACE_LSB       = 13;
    // control register fields
    localparam int          DCE_BIT         = 0;
    localparam int          DC_BIT          = 1;
    // address-space codes
    localparam logic [2:0]  SPACE_USER_DATA = 3'h1;
    localparam logic [2:0]  SPACE_SUP_DATA  = 3'h5;
    localparam logic [2:0]  SPACE_IACK      = 3'h7;
    localparam int          PB_IRQ_W        = 4;
    localparam int          LVL_IRQ_W       = 3;
endpackage
`default_nettype wire

// ---- hdl/pin_sync.sv ----
// two-flop synchroniser for a group of pin levels
// assumes each bit is an independent, slowly changing level
`default_nettype none
module pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ---- hdl/base_match.sv ----
// address match against the programmed peripheral block base
// assumes the address and space code are already resolved by the caller
`default_nettype none
module base_match
    import pbd_pkg::*;
(
    input  wire logic [pbd_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [pbd_pkg::SPACE_W-1:0] space_i,
    input  wire logic [pbd_pkg::DATA_W-1:0]  base_i,
    input  wire logic                        valid_i,
    output logic                             hit_o
);
    import pbd_pkg::*;

    logic addr_ok;
    logic space_ok;

    always_comb begin
        // only bits above the 4K block are compared
        addr_ok  = addr_i[ADDR_W-1:BLOCK_BITS] == base_i[BASE_FIELD_MSB:0];
        space_ok = !base_i[CFC_BIT] || (space_i == base_i[DATA_W-1:SPACE_LSB]);
        hit_o    = valid_i && addr_ok && space_ok;
    end
endmodule // base_match
`default_nettype wire

// ---- hdl/peripheral_base_decode.sv ----
// peripheral block base decoder with fixed base and control registers
// assumes a one-cycle request from the bus master on clk_i;
// pin-level straps and interrupts from outside pass through synchronisers
`default_nettype none

// Overview of operation
// - one 4K block holds all peripheral registers
// - base bits 11-0 match address above block
// - space code compared only when compare bit set
// - no block access until base is written
// - base reads BFFF after total reset
// - only reset plus halt resets the registers
// - base fixed at 0F2 in supervisor data
// - user data accesses to base get no answer
// - chip selects inhibited on fixed register accesses
// - 8-bit bus needs low base byte written
// - outside decode in block sets conflict, error if enabled and core not disabled
// - external master accesses use space code 5
// - external master top address bits forced zero
// - byte pins: write enables or data strobes
// - output enable pin or read/write direction
// - halted core: no external internal access
// - core disabled: only port B 8-11 interrupt
module peripheral_base_decode
    import pbd_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          reset_pin_n_i,
    input  wire logic                          halt_n_i,
    input  wire logic                          core_disable_i,
    input  wire logic                          bus_width_select_i,
    input  wire logic                          ext_decode_i,
    input  wire logic [pbd_pkg::PB_IRQ_W-1:0]  port_b_irq_i,
    input  wire logic [pbd_pkg::LVL_IRQ_W-1:0] level_irq_n_i,
    input  wire logic                          req_i,
    input  wire logic                          write_i,
    input  wire logic                          byte_hi_i,
    input  wire logic                          byte_lo_i,
    input  wire logic [pbd_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [pbd_pkg::SPACE_W-1:0]   space_code_i,
    input  wire logic [pbd_pkg::DATA_W-1:0]    wdata_i,
    output logic [pbd_pkg::DATA_W-1:0]         rdata_o,
    output logic                               ack_o,
    output logic                               bus_error_signal_o,
    output logic                               periph_select_o,
    output logic                               cs_inhibit_o,
    output logic [pbd_pkg::ADDR_W-1:0]         int_addr_o,
    output logic [pbd_pkg::SPACE_W-1:0]        int_space_code_o,
    output logic                               byte_hi_pin_n_o,
    output logic                               byte_lo_pin_n_o,
    output logic                               oe_rw_pin_o,
    output logic                               irq_req_o,
    output logic [pbd_pkg::DATA_W-1:0]         base_reg_o,
    output logic                               base_valid_o
);
    import pbd_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]  base;
        logic               base_valid;
        logic               conflict_en;
        logic               conflict;
        logic [DATA_W-1:0]  rdata;
        logic               ack;
        logic               bus_error_signal;
        logic               periph_sel;
        logic               cs_inhibit;
        logic [ADDR_W-1:0]  int_addr;
        logic [SPACE_W-1:0] int_space;
        logic               hi_pin_n;
        logic               lo_pin_n;
        logic               oe_rw;
        logic               irq;
    } state_t;

    localparam state_t STATE_RESET = '{
        base:        BASE_RESET,
        base_valid:  1'b0,
        conflict_en: SCR_RESET[DCE_BIT],
        conflict:    SCR_RESET[DC_BIT],
        rdata:       '0,
        ack:         1'b0,
        bus_error_signal:        1'b0,
        periph_sel:  1'b0,
        cs_inhibit:  1'b0,
        int_addr:    '0,
        int_space:   '0,
        hi_pin_n:    1'b1,
        lo_pin_n:    1'b1,
        oe_rw:       1'b1,
        irq:         1'b0
    };

    state_t s;
    state_t next_s;

    // synchronised pin levels
    logic                 reset_pin_n_s;
    logic                 halt_n_s;
    logic                 core_dis_s;
    logic                 bus8_n_s;
    logic                 ext_decode_s;
    logic [PB_IRQ_W-1:0]  port_b_s;
    logic [LVL_IRQ_W-1:0] level_n_s;

    // pin groups as seen by the synchronisers
    localparam int        CTL_W  = 4;
    localparam int        MISC_W = PB_IRQ_W + LVL_IRQ_W + 1;
    logic [CTL_W-1:0]     ctl_d;
    logic [CTL_W-1:0]     ctl_q;
    logic [MISC_W-1:0]    misc_d;
    logic [MISC_W-1:0]    misc_q;
    logic [LVL_IRQ_W-2:0] level_hi_s;

    // reset and halt idle high so no false total reset follows power-on
    assign ctl_d  = {reset_pin_n_i, halt_n_i, bus_width_select_i, level_irq_n_i[0]};
    assign misc_d = {core_disable_i, ext_decode_i, port_b_irq_i, ~level_irq_n_i[LVL_IRQ_W-1:1]};

    pin_sync #(.W(CTL_W), .RST_VAL(4'hF)) u_sync_ctl (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (ctl_d),
        .q_o     (ctl_q)
    );

    pin_sync #(.W(MISC_W)) u_sync_misc (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (misc_d),
        .q_o     (misc_q)
    );

    assign reset_pin_n_s = ctl_q[3];
    assign halt_n_s      = ctl_q[2];
    assign bus8_n_s      = ctl_q[1];
    assign level_hi_s    = misc_q[LVL_IRQ_W-2:0];
    assign level_n_s     = {~level_hi_s, ctl_q[0]};
    assign core_dis_s    = misc_q[MISC_W-1];
    assign ext_decode_s  = misc_q[MISC_W-2];
    assign port_b_s      = misc_q[LVL_IRQ_W-1 +: PB_IRQ_W];

    // resolved address of the current access
    logic              ext_mode;
    logic              halted_ext;
    logic [ADDR_W-1:0] eff_addr;
    logic [SPACE_W-1:0] eff_space;
    logic              block_hit;

    always_comb begin
        // forcing applies under halt too, only the access itself is denied
        ext_mode   = core_dis_s || !halt_n_s;
        halted_ext = !halt_n_s && !core_dis_s;
        if (ext_mode) begin
            eff_addr  = {{TOP_BITS{1'b0}}, addr_i[ADDR_W-TOP_BITS-1:0]};
            eff_space = SPACE_SUP_DATA;
        end else begin
            eff_addr  = addr_i;
            eff_space = space_code_i;
        end
    end

    base_match u_match (
        .addr_i  (eff_addr),
        .space_i (eff_space),
        .base_i  (s.base),
        .valid_i (s.base_valid),
        .hit_o   (block_hit)
    );

    // same decode for both fixed registers
    function automatic logic at_word(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] w);
        at_word = a[ADDR_W-1:1] == w[ADDR_W-1:1];
    endfunction

    logic              total_reset;
    logic              bus8;
    logic              lane_hi;
    logic              lane_lo;
    logic              fixed_base;
    logic              fixed_scr;
    logic              reg_ok;
    logic [DATA_W-1:0] scr_word;
    logic [DATA_W-1:0] wr_word;

    always_comb begin
        // reset pin alone leaves the registers alone
        total_reset = !reset_pin_n_s && !halt_n_s;
        bus8        = !bus8_n_s;
        // 8-bit bus: even byte is the high byte, data on the low lane
        lane_hi     = bus8 ? !addr_i[0] : byte_hi_i;
        lane_lo     = bus8 ?  addr_i[0] : byte_lo_i;
        wr_word     = bus8 ? {wdata_i[7:0], wdata_i[7:0]} : wdata_i;
        fixed_base  = at_word(eff_addr, BASE_REG_ADDR);
        fixed_scr   = at_word(eff_addr, SCR_REG_ADDR);
        // user space is simply not answered
        reg_ok      = eff_space == SPACE_SUP_DATA && !halted_ext;
        scr_word    = '0;
        scr_word[DCE_BIT] = s.conflict_en;
        scr_word[DC_BIT]  = s.conflict;

        next_s            = s;
        next_s.ack        = 1'b0;
        next_s.bus_error_signal       = 1'b0;
        next_s.periph_sel = 1'b0;
        next_s.cs_inhibit = 1'b0;
        next_s.int_addr   = eff_addr;
        next_s.int_space  = eff_space;

        // pin roles follow the core mode
        // strobes need no write qualifier: the external master drives direction
        if (core_dis_s) begin
            next_s.hi_pin_n = !(req_i && lane_hi);
            next_s.lo_pin_n = !(req_i && lane_lo);
            next_s.oe_rw    = !(req_i && write_i);
        end else begin
            next_s.hi_pin_n = !(req_i && write_i && lane_hi);
            next_s.lo_pin_n = !(req_i && write_i && lane_lo);
            next_s.oe_rw    = !(req_i && !write_i);
        end

        // level lines serve as bus arbitration when the core is off
        if (core_dis_s) begin
            next_s.irq = |port_b_s;
        end else begin
            next_s.irq = |port_b_s || !(&level_n_s);
        end

        if (req_i) begin
            // chip selects stay off at the fixed locations
            next_s.cs_inhibit = fixed_base || fixed_scr;
            if (fixed_base && reg_ok) begin
                next_s.ack   = 1'b1;
                next_s.rdata = s.base;
                if (write_i) begin
                    if (lane_hi) begin
                        next_s.base[DATA_W-1:8] = wr_word[DATA_W-1:8];
                    end
                    if (lane_lo) begin
                        next_s.base[7:0] = wr_word[7:0];
                    end
                    // 8-bit bus waits for the low byte
                    if (lane_lo || !bus8) begin
                        next_s.base_valid = 1'b1;
                    end
                end
            end else if (fixed_scr && reg_ok) begin
                next_s.ack   = 1'b1;
                next_s.rdata = scr_word;
                if (write_i && lane_lo) begin
                    next_s.conflict_en = wr_word[DCE_BIT];
                    if (wr_word[DC_BIT]) begin
                        next_s.conflict = 1'b0;
                    end
                end
            end else if (block_hit && !halted_ext) begin
                next_s.periph_sel = 1'b1;
                // a total reset in the same cycle wins over this set
                if (ext_decode_s) begin
                    next_s.conflict = 1'b1;
                    next_s.bus_error_signal     = s.conflict_en && !ext_mode;
                end
            end
        end

        if (total_reset) begin
            // total reset also restores the control register
            next_s.base        = BASE_RESET;
            next_s.base_valid  = 1'b0;
            next_s.conflict_en = SCR_RESET[DCE_BIT];
            next_s.conflict    = SCR_RESET[DC_BIT];
        end
    end

    // one register for all state keeps reset and update together
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o            = s.rdata;
    assign ack_o              = s.ack;
    assign bus_error_signal_o = s.bus_error_signal;
    assign periph_select_o    = s.periph_sel;
    assign cs_inhibit_o       = s.cs_inhibit;
    assign int_addr_o         = s.int_addr;
    assign int_space_code_o   = s.int_space;
    assign byte_hi_pin_n_o    = s.hi_pin_n;
    assign byte_lo_pin_n_o    = s.lo_pin_n;
    assign oe_rw_pin_o        = s.oe_rw;
    assign irq_req_o          = s.irq;
    assign base_reg_o         = s.base;
    assign base_valid_o       = s.base_valid;
endmodule // peripheral_base_decode
`default_nettype wire

// ---- test/bus_master_model.sv ----
// bus master model: one-cycle requests on clk_i, answer taken one cycle later
// assumes the decoder registers every answer
`default_nettype none
module bus_master_model
    import pbd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic        sel_i,
    input  wire logic        err_i,
    input  wire logic        csi_i,
    input  wire logic [15:0] rdata_i,
    output var  logic        req_o,
    output var  logic        write_o,
    output var  logic        hi_o,
    output var  logic        lo_o,
    output var  logic [23:0] addr_o,
    output var  logic [2:0]  space_o,
    output var  logic [15:0] wdata_o
);
    timeunit 1ns / 1ps;
    logic [3:0]  ans;
    logic [15:0] rd;
    logic [1:0]  lanes = 2'b11;
    initial {req_o, write_o, hi_o, lo_o, addr_o, space_o, wdata_o} = '0;
    // ans holds ack, select, error, inhibit
    task automatic xfer(input logic w, input logic [23:0] a, input logic [2:0] s, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        {req_o, write_o, hi_o, lo_o, addr_o, space_o, wdata_o} = {1'b1, w, lanes, a, s, d};
        @(posedge clk_i);
        #1;
        ans = {ack_i, sel_i, err_i, csi_i};
        rd = rdata_i;
        // released lines show the inverse, so a stale value cannot pass
        {req_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
    endtask
endmodule // bus_master_model
`default_nettype wire

// ---- test/peripheral_base_decode_sva.sv ----
// assertions on the decoder ports: answers, selects and pin roles
// assumes mode pins pass a two-flop synchroniser inside the decoder
`default_nettype none
module peripheral_base_decode_sva
    import pbd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        halt_n_i,
    input wire logic        core_disable_i,
    input wire logic        req_i,
    input wire logic        write_i,
    input wire logic [23:0] addr_i,
    input wire logic [2:0]  space_code_i,
    input wire logic        ack_o,
    input wire logic        periph_select_o,
    input wire logic        cs_inhibit_o,
    input wire logic [23:0] int_addr_o,
    input wire logic [2:0]  int_space_code_o,
    input wire logic        byte_hi_pin_n_o,
    input wire logic        byte_lo_pin_n_o,
    input wire logic        oe_rw_pin_o,
    input wire logic [15:0] base_reg_o,
    input wire logic        base_valid_o
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // a mode counts only after three still edges, to outlast the synchroniser
    logic [8:0] hist;
    wire logic [2:0] now = {~halt_n_i & ~core_disable_i, halt_n_i & ~core_disable_i, core_disable_i};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hist <= '0;
        end else begin
            hist <= {hist[5:0], now};
        end
    end
    wire logic hlt_m = hist[2] & hist[5] & hist[8] & now[2];
    wire logic cpu_m = hist[1] & hist[4] & hist[7] & now[1];
    wire logic dis_m = hist[0] & hist[3] & hist[6] & now[0];
    a_user_base: assert property (req_i && cpu_m && addr_i == BASE_REG_ADDR && space_code_i != 3'h5 |=> !ack_o)
        else $error("base answered outside supervisor data");
    a_fixed_inhibit: assert property (req_i && cpu_m && space_code_i == 3'h5 && (addr_i == BASE_REG_ADDR
        || addr_i == SCR_REG_ADDR) |=> ack_o && cs_inhibit_o) else $error("fixed register missed");
    a_select_valid: assert property (periph_select_o |-> $past(base_valid_o))
        else $error("select before base written");
    a_select_range: assert property (periph_select_o |-> int_addr_o[23:12] == $past(base_reg_o[11:0]))
        else $error("select outside block");
    a_space_cmp: assert property (periph_select_o && $past(base_reg_o[12])
        |-> int_space_code_o == $past(base_reg_o[15:13])) else $error("select with wrong space");
    a_valid_rise: assert property ($rose(base_valid_o) |-> ack_o && cs_inhibit_o)
        else $error("base valid without base write");
    a_halt_deny: assert property (req_i && hlt_m |=> !ack_o && !periph_select_o)
        else $error("halted core gave internal access");
    a_ext_force: assert property (req_i && (hlt_m || dis_m) |=> int_space_code_o == 3'h5
        && int_addr_o[23:20] == 4'h0) else $error("external access not forced");
    a_read_pins: assert property (req_i && !write_i && cpu_m |=> !oe_rw_pin_o && byte_hi_pin_n_o
        && byte_lo_pin_n_o) else $error("read pins wrong with core on");
    c_select: cover property (periph_select_o);
    c_fixed: cover property (ack_o && cs_inhibit_o);
    c_halt: cover property (req_i && hlt_m);
    c_slave: cover property (req_i && dis_m);
endmodule // peripheral_base_decode_sva
bind peripheral_base_decode peripheral_base_decode_sva u_sva (
    .clk_i, .rst_n_i, .halt_n_i, .core_disable_i, .req_i, .write_i, .addr_i, .space_code_i, .ack_o,
    .periph_select_o, .cs_inhibit_o, .int_addr_o, .int_space_code_o, .byte_hi_pin_n_o, .byte_lo_pin_n_o,
    .oe_rw_pin_o, .base_reg_o, .base_valid_o
);
`default_nettype wire

// ---- test/peripheral_base_decode_test.sv ----
// self-checking bench for the peripheral block base decoder
// assumes the bus master model drives the request port group
`default_nettype none
module peripheral_base_decode_test;
    import pbd_pkg::*;
    timeunit 1ns / 1ps;
    logic clk_i, rst_n_i, reset_pin_n_i, halt_n_i, core_disable_i, bus_width_select_i, ext_decode_i;
    logic req_i, write_i, byte_hi_i, byte_lo_i, ack_o, bus_error_signal_o, periph_select_o, cs_inhibit_o;
    logic byte_hi_pin_n_o, byte_lo_pin_n_o, oe_rw_pin_o, irq_req_o, base_valid_o;
    logic [3:0]  port_b_irq_i;
    logic [2:0]  level_irq_n_i, space_code_i, int_space_code_o;
    logic [23:0] addr_i, int_addr_o;
    logic [15:0] wdata_i, rdata_o, base_reg_o;
    int err_total = 0;
    int num_checks = 0;
    peripheral_base_decode dut (
        .clk_i, .rst_n_i, .reset_pin_n_i, .halt_n_i, .core_disable_i, .bus_width_select_i, .ext_decode_i,
        .port_b_irq_i, .level_irq_n_i, .req_i, .write_i, .byte_hi_i, .byte_lo_i, .addr_i, .space_code_i,
        .wdata_i, .rdata_o, .ack_o, .bus_error_signal_o, .periph_select_o, .cs_inhibit_o, .int_addr_o,
        .int_space_code_o, .byte_hi_pin_n_o, .byte_lo_pin_n_o, .oe_rw_pin_o, .irq_req_o, .base_reg_o, .base_valid_o
    );
    bus_master_model bm (
        .clk_i, .ack_i(ack_o), .sel_i(periph_select_o), .err_i(bus_error_signal_o), .csi_i(cs_inhibit_o),
        .rdata_i(rdata_o), .req_o(req_i), .write_o(write_i), .hi_o(byte_hi_i), .lo_o(byte_lo_i),
        .addr_o(addr_i), .space_o(space_code_i), .wdata_o(wdata_i)
    );
    task automatic chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t check %0d mismatch", $time, num_checks);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // bus width only changes under power-on reset, never while running
    task automatic por(input logic w);
        rst_n_i = 1'b0;
        bus_width_select_i = w;
        step(10);
        rst_n_i = 1'b1;
        step(4);
    endtask
    task automatic t_after_reset;
        bm.xfer(1, 24'h0000F2, 3'h1, 16'h0012);
        chk(bm.ans[3] === 1'b0);
        bm.xfer(0, 24'h0000F2, 3'h5, 16'h0);
        chk(bm.ans === 4'b1001 && bm.rd === 16'hBFFF);
        bm.xfer(0, 24'hFFF000, 3'h5, 16'h0);
        chk(bm.ans[2] === 1'b0 && base_valid_o === 1'b0);
    endtask
    task automatic t_place;
        bm.xfer(1, 24'h0000F2, 3'h5, 16'h0012);
        chk(bm.ans === 4'b1001 && base_reg_o === 16'h0012);
        chk({byte_hi_pin_n_o, byte_lo_pin_n_o, oe_rw_pin_o} === 3'b001);
        bm.xfer(0, 24'h012FFE, 3'h5, 16'h0);
        chk(bm.ans === 4'b0100 && oe_rw_pin_o === 1'b0);
        bm.xfer(0, 24'h013000, 3'h5, 16'h0);
        chk(bm.ans[2] === 1'b0);
        bm.xfer(0, 24'h011FFF, 3'h5, 16'h0);
        chk(bm.ans[2] === 1'b0);
    endtask
    task automatic t_space;
        bm.xfer(1, 24'h0000F2, 3'h5, 16'hB012);
        bm.xfer(0, 24'h012000, 3'h5, 16'h0);
        chk(bm.ans[2] === 1'b1);
        bm.xfer(0, 24'h012000, 3'h6, 16'h0);
        chk(bm.ans[2] === 1'b0);
        bm.xfer(1, 24'h0000F2, 3'h5, 16'h0012);
        bm.xfer(0, 24'h012000, 3'h6, 16'h0);
        chk(bm.ans[2] === 1'b1);
    endtask
    task automatic t_conflict;
        bm.xfer(1, 24'h0000F4, 3'h5, 16'h0001);
        ext_decode_i = 1'b1;
        step(3);
        bm.xfer(0, 24'h012010, 3'h5, 16'h0);
        chk(bm.ans[2:1] === 2'b11);
        ext_decode_i = 1'b0;
        bm.xfer(0, 24'h0000F4, 3'h5, 16'h0);
        chk(bm.rd === 16'h0003);
        bm.xfer(1, 24'h0000F4, 3'h5, 16'h0002);
        bm.xfer(0, 24'h0000F4, 3'h5, 16'h0);
        chk(bm.rd === 16'h0000);
    endtask
    task automatic t_reset_pin;
        bm.xfer(1, 24'h0000F4, 3'h5, 16'h0001);
        reset_pin_n_i = 1'b0;
        step(5);
        reset_pin_n_i = 1'b1;
        bm.xfer(0, 24'h0000F4, 3'h5, 16'h0);
        chk(bm.rd === 16'h0001 && base_reg_o === 16'h0012 && base_valid_o === 1'b1);
        {reset_pin_n_i, halt_n_i} = 2'b00;
        step(5);
        {reset_pin_n_i, halt_n_i} = 2'b11;
        step(4);
        bm.xfer(0, 24'h0000F4, 3'h5, 16'h0);
        chk(bm.rd === 16'h0000 && base_reg_o === 16'hBFFF && base_valid_o === 1'b0);
        bm.xfer(1, 24'h0000F2, 3'h5, 16'h0012);
    endtask
    task automatic t_halt;
        halt_n_i = 1'b0;
        step(4);
        bm.xfer(0, 24'hF12000, 3'h2, 16'h0);
        chk(bm.ans === 4'b0000);
        chk(int_addr_o === 24'h012000 && int_space_code_o === 3'h5);
        halt_n_i = 1'b1;
        step(4);
    endtask
    task automatic t_slave;
        {core_disable_i, level_irq_n_i} = {1'b1, 3'h6};
        step(4);
        chk(irq_req_o === 1'b0);
        bm.lanes = 2'b10;
        bm.xfer(1, 24'hF12000, 3'h2, 16'h0);
        chk(bm.ans[2] === 1'b1 && int_addr_o === 24'h012000 && int_space_code_o === 3'h5);
        chk({byte_hi_pin_n_o, byte_lo_pin_n_o, oe_rw_pin_o} === 3'b010);
        bm.lanes = 2'b11;
        bm.xfer(0, 24'h012000, 3'h2, 16'h0);
        chk({byte_hi_pin_n_o, byte_lo_pin_n_o, oe_rw_pin_o} === 3'b001);
        port_b_irq_i = 4'h8;
        step(4);
        chk(irq_req_o === 1'b1);
        {core_disable_i, port_b_irq_i} = {1'b0, 4'h0};
        step(5);
        chk(irq_req_o === 1'b1);
        level_irq_n_i = 3'h7;
    endtask
    task automatic t_narrow;
        por(1'b0);
        bm.xfer(1, 24'h0000F2, 3'h5, 16'h0000);
        chk(bm.ans[3] === 1'b1 && base_valid_o === 1'b0);
        bm.xfer(0, 24'h0FF000, 3'h5, 16'h0);
        chk(bm.ans[2] === 1'b0);
        bm.xfer(1, 24'h0000F3, 3'h5, 16'h0012);
        chk(base_valid_o === 1'b1 && base_reg_o === 16'h0012);
        bm.xfer(0, 24'h012000, 3'h5, 16'h0);
        chk(bm.ans[2] === 1'b1);
    endtask
    task automatic end_of_test;
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        err_total++;
        end_of_test();
    end
    initial begin
        {reset_pin_n_i, halt_n_i, core_disable_i, ext_decode_i} = 4'b1100;
        {port_b_irq_i, level_irq_n_i} = {4'h0, 3'h7};
        por(1'b1);
        t_after_reset();
        t_place();
        t_space();
        t_conflict();
        t_reset_pin();
        t_halt();
        t_slave();
        t_narrow();
        end_of_test();
    end
endmodule // peripheral_base_decode_test
`default_nettype wire
